// >>> pkg/ifmsc_pkg.sv
package ifmsc_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [31:0] ADDR_NORMAL_ENABLED_STATUS = 32'hffff_0000;
  localparam logic [31:0] ADDR_NORMAL_RAW_SIGNAL     = 32'hffff_0004;
  localparam logic [31:0] ADDR_NORMAL_ENABLE_MASK    = 32'hffff_0008;
  localparam logic [31:0] ADDR_NORMAL_MASK_CLEAR     = 32'hffff_000c;
  localparam logic [31:0] ADDR_SOFTWARE_INT_CONFIG   = 32'hffff_0010;
  localparam logic [31:0] ADDR_FAST_ENABLED_STATUS   = 32'hffff_0100;
  localparam logic [31:0] ADDR_FAST_RAW_SIGNAL       = 32'hffff_0104;
  localparam logic [31:0] ADDR_FAST_ENABLE_MASK      = 32'hffff_0108;
  localparam logic [31:0] ADDR_FAST_MASK_CLEAR       = 32'hffff_010c;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int          DATA_W    = 32;
  localparam int          SRC_LO    = 2;
  localparam int          SRC_HI    = 25;
  localparam int          SRC_N     = SRC_HI - SRC_LO + 1;
  localparam logic [31:0] RST_VAL   = 32'h0000_0000;
  localparam logic [31:0] USED_MASK = 32'h03ff_ffff;

  // ----------------------------------------
  // Source bit positions
  // ----------------------------------------
  localparam int POS_FAST_ANY   = 0;
  localparam int POS_SOFTWARE   = 1;
  localparam int POS_TIMER0     = 2;
  localparam int POS_TIMER1     = 3;
  localparam int POS_TIMER2     = 4;
  localparam int POS_TIMER3     = 5;
  localparam int POS_FLASH0     = 6;
  localparam int POS_FLASH1     = 7;
  localparam int POS_CONVERTER  = 8;
  localparam int POS_SERIAL0    = 9;
  localparam int POS_SERIAL1    = 10;
  localparam int POS_PLL_LOCK   = 11;
  localparam int POS_TWI0_MST   = 12;
  localparam int POS_TWI0_SLV   = 13;
  localparam int POS_TWI1_MST   = 14;
  localparam int POS_TWI1_SLV   = 15;
  localparam int POS_SPI        = 16;
  localparam int POS_EXT_ZERO   = 17;
  localparam int POS_COMPARATOR = 18;
  localparam int POS_SUPPLY_MON = 19;
  localparam int POS_EXT_ONE    = 20;
  localparam int POS_LAB_A      = 21;
  localparam int POS_EXT_TWO    = 22;
  localparam int POS_EXT_THREE  = 23;
  localparam int POS_LAB_B      = 24;
  localparam int POS_PWM_TRIP   = 25;

  // ----------------------------------------
  // Software interrupt config fields
  // ----------------------------------------
  localparam int          SWI_NORMAL_BIT = 1;
  localparam int          SWI_FAST_BIT   = 2;
  localparam logic [31:0] SWI_MASK       = 32'h0000_0006;

endpackage

// >>> design/ifmsc_sync.sv
module ifmsc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // ----------------------------------------
  // Two-flop synchroniser
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
    end
  end

  assign o_sync = stage2_reg;

endmodule // ifmsc_sync

// >>> design/ifmsc_mask_bank.sv
module ifmsc_mask_bank (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Set and clear requests
  input  wire logic        i_set_we,
  input  wire logic [31:0] i_set_data,
  input  wire logic        i_clr_we,
  input  wire logic [31:0] i_clr_data,
  // Current enable mask
  output logic      [31:0] o_en
);

  logic [31:0] en_reg;
  logic [31:0] en_next;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;

  // Ones set, zeros never clear; unused positions stay zero
  assign set_bits = i_set_we ? (i_set_data & ifmsc_pkg::USED_MASK) : '0;
  assign clr_bits = i_clr_we ? i_clr_data : '0;
  assign en_next  = (en_reg & ~clr_bits) | set_bits;

  // ----------------------------------------
  // Enable mask storage
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      en_reg <= ifmsc_pkg::RST_VAL;
    end else begin
      en_reg <= en_next;
    end
  end

  assign o_en = en_reg;

endmodule // ifmsc_mask_bank

// >>> design/ifmsc_top.sv
// Design decision made here: strobed register access.
module ifmsc_top (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Peripheral interrupt lines, active high levels
  input  wire logic        i_timer0_int,
  input  wire logic        i_timer1_int,
  input  wire logic        i_timer2_int,
  input  wire logic        i_timer3_int,
  // Flash blocks
  input  wire logic        i_flash0_int,
  input  wire logic        i_flash1_int,
  // Converter, serial ports and clock lock
  input  wire logic        i_converter_int,
  input  wire logic        i_serial0_int,
  input  wire logic        i_serial1_int,
  input  wire logic        i_pll_lock_int,
  // Two-wire channels
  input  wire logic        i_twi0_master_int,
  input  wire logic        i_twi0_slave_int,
  input  wire logic        i_twi1_master_int,
  input  wire logic        i_twi1_slave_int,
  // SPI, low external lines, comparator, supply monitor
  input  wire logic        i_spi_int,
  input  wire logic        i_external_line_zero,
  input  wire logic        i_comparator_int,
  input  wire logic        i_supply_monitor_int,
  input  wire logic        i_external_line_one,
  // Logic arrays, upper external lines, PWM trip
  input  wire logic        i_logic_array_block_a_int,
  input  wire logic        i_external_line_two,
  input  wire logic        i_external_line_three,
  input  wire logic        i_logic_array_block_b_int,
  input  wire logic        i_pwm_trip_int,
  // Exception requests to the core
  output logic             o_irq,
  output logic             o_fiq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0] src_async;
  logic [31:0] src_sync;
  logic [31:0] swi_cfg_reg;
  logic [31:0] swi_cfg_next;
  logic [31:0] normal_en;
  logic [31:0] fast_en;
  logic [31:0] normal_raw;
  logic [31:0] fast_raw;
  logic [31:0] normal_sta;
  logic [31:0] fast_sta;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] rd_sel;
  logic        fast_any;
  logic        irq_reg;
  logic        fiq_reg;
  logic [31:1] fast_sta_hi;
  logic        irq_any;

  // Address decode
  logic hit_n_sta;
  logic hit_n_raw;
  logic hit_n_en;
  logic hit_n_clr;
  logic hit_swi;
  logic hit_f_sta;
  logic hit_f_raw;
  logic hit_f_en;
  logic hit_f_clr;

  // Write strobes per register
  logic wr_n_en;
  logic wr_n_clr;
  logic wr_f_en;
  logic wr_f_clr;
  logic wr_swi;

  // Clear vectors for each bank
  logic [31:0] n_clr_bits;
  logic [31:0] f_clr_bits;
  logic        n_clr_we;
  logic        f_clr_we;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Full 32-bit compare of the bus address with one register
  function automatic logic addr_is(
    input logic [31:0] addr,
    input logic [31:0] reg_addr
  );
    return (addr == reg_addr);
  endfunction

  // Raw AND enable; the programmed bit passes unmasked
  function automatic logic [31:0] bank_status(
    input logic [31:0] raw,
    input logic [31:0] en
  );
    logic [31:0] sta;
    sta = raw & en;
    sta[ifmsc_pkg::POS_SOFTWARE] = raw[ifmsc_pkg::POS_SOFTWARE];
    return sta;
  endfunction

  // ----------------------------------------
  // Source map onto bit positions
  // ----------------------------------------
  // Low positions: bit 0 and 1 are built internally
  assign src_async[ifmsc_pkg::POS_FAST_ANY]   = 1'b0;
  assign src_async[ifmsc_pkg::POS_SOFTWARE]   = 1'b0;

  // Timers and flash blocks
  assign src_async[ifmsc_pkg::POS_TIMER0]     = i_timer0_int;
  assign src_async[ifmsc_pkg::POS_TIMER1]     = i_timer1_int;
  assign src_async[ifmsc_pkg::POS_TIMER2]     = i_timer2_int;
  assign src_async[ifmsc_pkg::POS_TIMER3]     = i_timer3_int;
  assign src_async[ifmsc_pkg::POS_FLASH0]     = i_flash0_int;
  assign src_async[ifmsc_pkg::POS_FLASH1]     = i_flash1_int;

  // Converter, serial ports and clock lock
  assign src_async[ifmsc_pkg::POS_CONVERTER]  = i_converter_int;
  assign src_async[ifmsc_pkg::POS_SERIAL0]    = i_serial0_int;
  assign src_async[ifmsc_pkg::POS_SERIAL1]    = i_serial1_int;
  assign src_async[ifmsc_pkg::POS_PLL_LOCK]   = i_pll_lock_int;

  // Two-wire channels, SPI, low external lines, comparator and supply monitor
  assign src_async[ifmsc_pkg::POS_TWI0_MST]   = i_twi0_master_int;
  assign src_async[ifmsc_pkg::POS_TWI0_SLV]   = i_twi0_slave_int;
  assign src_async[ifmsc_pkg::POS_TWI1_MST]   = i_twi1_master_int;
  assign src_async[ifmsc_pkg::POS_TWI1_SLV]   = i_twi1_slave_int;
  assign src_async[ifmsc_pkg::POS_SPI]        = i_spi_int;
  assign src_async[ifmsc_pkg::POS_EXT_ZERO]   = i_external_line_zero;
  assign src_async[ifmsc_pkg::POS_COMPARATOR] = i_comparator_int;
  assign src_async[ifmsc_pkg::POS_SUPPLY_MON] = i_supply_monitor_int;
  assign src_async[ifmsc_pkg::POS_EXT_ONE]    = i_external_line_one;

  // Upper positions
  assign src_async[ifmsc_pkg::POS_LAB_A]     = i_logic_array_block_a_int;
  assign src_async[ifmsc_pkg::POS_EXT_TWO]   = i_external_line_two;
  assign src_async[ifmsc_pkg::POS_EXT_THREE] = i_external_line_three;
  assign src_async[ifmsc_pkg::POS_LAB_B]     = i_logic_array_block_b_int;
  assign src_async[ifmsc_pkg::POS_PWM_TRIP]  = i_pwm_trip_int;

  // Unused positions never assert
  assign src_async[31:ifmsc_pkg::SRC_HI+1] = '0;

  // ----------------------------------------
  // Source synchronisers
  // ----------------------------------------
  // Lines must be high at one rising clock edge to be seen, two clocks later
  ifmsc_sync #(
    .WIDTH (ifmsc_pkg::SRC_N)
  ) u_src_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (src_async[ifmsc_pkg::SRC_HI:ifmsc_pkg::SRC_LO]),
    .o_sync  (src_sync[ifmsc_pkg::SRC_HI:ifmsc_pkg::SRC_LO])
  );

  assign src_sync[ifmsc_pkg::SRC_LO-1:0] = '0;
  assign src_sync[31:ifmsc_pkg::SRC_HI+1] = '0;

  // ----------------------------------------
  // Address decode and write strobes
  // ----------------------------------------
  assign hit_n_sta = addr_is(i_addr, ifmsc_pkg::ADDR_NORMAL_ENABLED_STATUS);
  assign hit_n_raw = addr_is(i_addr, ifmsc_pkg::ADDR_NORMAL_RAW_SIGNAL);
  assign hit_n_en  = addr_is(i_addr, ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK);
  assign hit_n_clr = addr_is(i_addr, ifmsc_pkg::ADDR_NORMAL_MASK_CLEAR);
  assign hit_swi   = addr_is(i_addr, ifmsc_pkg::ADDR_SOFTWARE_INT_CONFIG);
  assign hit_f_sta = addr_is(i_addr, ifmsc_pkg::ADDR_FAST_ENABLED_STATUS);
  assign hit_f_raw = addr_is(i_addr, ifmsc_pkg::ADDR_FAST_RAW_SIGNAL);
  assign hit_f_en  = addr_is(i_addr, ifmsc_pkg::ADDR_FAST_ENABLE_MASK);
  assign hit_f_clr = addr_is(i_addr, ifmsc_pkg::ADDR_FAST_MASK_CLEAR);

  // Status and raw registers take no write
  assign wr_n_en  = i_wr & hit_n_en;
  assign wr_n_clr = i_wr & hit_n_clr;
  assign wr_f_en  = i_wr & hit_f_en;
  assign wr_f_clr = i_wr & hit_f_clr;
  assign wr_swi   = i_wr & hit_swi;

  // ----------------------------------------
  // Enable mask banks
  // ----------------------------------------
  // Clear-register ones, or ones set in the other bank
  assign n_clr_bits = (wr_n_clr ? i_wdata : '0)
                    | (wr_f_en  ? i_wdata : '0);
  assign f_clr_bits = (wr_f_clr ? i_wdata : '0)
                    | (wr_n_en  ? i_wdata : '0);

  // A bank clears on its own clear write or the other bank's set
  assign n_clr_we = wr_n_clr | wr_f_en;
  assign f_clr_we = wr_f_clr | wr_n_en;

  // Normal mask: ones set, zeros ignored
  ifmsc_mask_bank u_normal_bank (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_set_we   (wr_n_en),
    .i_set_data (i_wdata),
    .i_clr_we   (n_clr_we),
    .i_clr_data (n_clr_bits),
    .o_en       (normal_en)
  );

  // Fast mask: ones set, zeros ignored
  ifmsc_mask_bank u_fast_bank (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_set_we   (wr_f_en),
    .i_set_data (i_wdata),
    .i_clr_we   (f_clr_we),
    .i_clr_data (f_clr_bits),
    .o_en       (fast_en)
  );

  // ----------------------------------------
  // Software interrupt config
  // ----------------------------------------
  // Only bits 2 and 1 exist; reserved bits stay zero
  assign swi_cfg_next = wr_swi ? (i_wdata & ifmsc_pkg::SWI_MASK) : swi_cfg_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      swi_cfg_reg <= ifmsc_pkg::RST_VAL;
    end else begin
      swi_cfg_reg <= swi_cfg_next;
    end
  end

  // ----------------------------------------
  // Raw signal vectors
  // ----------------------------------------
  // Peripheral bits follow the lines, masks play no part
  always_comb begin
    normal_raw = src_sync;
    normal_raw[ifmsc_pkg::POS_FAST_ANY] = fast_any;
    normal_raw[ifmsc_pkg::POS_SOFTWARE] =
      swi_cfg_reg[ifmsc_pkg::SWI_NORMAL_BIT];
  end

  always_comb begin
    fast_raw = src_sync;
    fast_raw[ifmsc_pkg::POS_FAST_ANY] = fast_any;
    fast_raw[ifmsc_pkg::POS_SOFTWARE] =
      swi_cfg_reg[ifmsc_pkg::SWI_FAST_BIT];
  end

  // ----------------------------------------
  // Enabled status vectors
  // ----------------------------------------
  // Raw AND enable; programmed bit bypasses the mask
  assign normal_sta = bank_status(normal_raw, normal_en);
  assign fast_sta   = bank_status(fast_raw, fast_en);

  // Fast status bits 31-1 straight from the sources, so the
  // aggregate never loops back through its own raw bit 0
  assign fast_sta_hi = {src_sync[31:2] & fast_en[31:2],
                        swi_cfg_reg[ifmsc_pkg::SWI_FAST_BIT]};

  // Aggregate fast source from bits 31 down to 1
  assign fast_any = |fast_sta_hi;

  // ----------------------------------------
  // Core request outputs
  // ----------------------------------------
  // Plain OR, software finds the source itself
  assign irq_any = |normal_sta;

  // Normal request register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_any;
    end
  end

  // Fast request register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fiq_reg <= 1'b0;
    end else begin
      fiq_reg <= fast_any;
    end
  end

  assign o_irq = irq_reg;
  assign o_fiq = fiq_reg;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Clear registers are write-only and read zero
  assign rd_sel = ({32{hit_n_sta}} & normal_sta)
                | ({32{hit_n_raw}} & normal_raw)
                | ({32{hit_n_en}}  & normal_en)
                | ({32{hit_swi}}   & swi_cfg_reg)
                | ({32{hit_f_sta}} & fast_sta)
                | ({32{hit_f_raw}} & fast_raw)
                | ({32{hit_f_en}}  & fast_en);

  // Data stand one cycle after the strobe only
  assign rdata_next = i_rd ? (rd_sel & ifmsc_pkg::USED_MASK) : '0;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= ifmsc_pkg::RST_VAL;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

endmodule // ifmsc_top

// >>> dv/ifmsc_monitor.sv
module ifmsc_monitor (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [31:0] o_rdata,
  // Exception requests
  input  wire logic        o_irq,
  input  wire logic        o_fiq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Bus cycle shapes
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_wr(logic [31:0] a);
    i_wr && i_addr == a;
  endsequence
  sequence s_rd(logic [31:0] a);
    i_rd && i_addr == a;
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_quiet;
    $fell(i_rst) |-> !o_irq && !o_fiq && o_rdata == 32'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
  property p_top_zero;
    o_rdata[31:26] == 6'h0;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("unused bits read set");
  property p_set;
    s_wr(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK) ##1 s_rd(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK)
      |=> (o_rdata & $past(i_wdata, 2) & ifmsc_pkg::USED_MASK)
          == ($past(i_wdata, 2) & ifmsc_pkg::USED_MASK);
  endproperty
  a_set: assert property (p_set) else $error("written enable ones missing");
  property p_nclr;
    s_wr(ifmsc_pkg::ADDR_NORMAL_MASK_CLEAR) ##1 s_rd(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK)
      |=> (o_rdata & $past(i_wdata, 2)) == 32'h0;
  endproperty
  a_nclr: assert property (p_nclr) else $error("normal clear left bits");
  property p_fclr;
    s_wr(ifmsc_pkg::ADDR_FAST_MASK_CLEAR) ##1 s_rd(ifmsc_pkg::ADDR_FAST_ENABLE_MASK)
      |=> (o_rdata & $past(i_wdata, 2)) == 32'h0;
  endproperty
  a_fclr: assert property (p_fclr) else $error("fast clear left bits");
  property p_excl;
    s_wr(ifmsc_pkg::ADDR_FAST_ENABLE_MASK) ##1 s_rd(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK)
      |=> (o_rdata & $past(i_wdata, 2)) == 32'h0;
  endproperty
  a_excl: assert property (p_excl) else $error("source enabled in both banks");
  property p_irq_or;
    $past(i_rd) && $past(i_addr) == ifmsc_pkg::ADDR_NORMAL_ENABLED_STATUS |-> o_irq == |o_rdata;
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq differs from status");
  property p_fiq_or;
    $past(i_rd) && $past(i_addr) == ifmsc_pkg::ADDR_FAST_ENABLED_STATUS
      |-> o_fiq == |o_rdata[31:1];
  endproperty
  a_fiq_or: assert property (p_fiq_or) else $error("fiq differs from status");
  property p_swi_irq;
    s_wr(ifmsc_pkg::ADDR_SOFTWARE_INT_CONFIG) and i_wdata[1] |-> ##2 o_irq;
  endproperty
  a_swi_irq: assert property (p_swi_irq) else $error("programmed irq missing");
  property p_swi_fiq;
    s_wr(ifmsc_pkg::ADDR_SOFTWARE_INT_CONFIG) and i_wdata[2] |-> ##2 o_fiq;
  endproperty
  a_swi_fiq: assert property (p_swi_fiq) else $error("programmed fiq missing");
endmodule // ifmsc_monitor

bind ifmsc_top ifmsc_monitor ifmsc_monitor_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_fiq(o_fiq));

// >>> dv/ifmsc_core_model.sv
module ifmsc_core_model (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Exception requests from the controller
  input  wire logic i_irq,
  input  wire logic i_fiq,
  // Exception levels taken by the core
  output logic      o_irq_seen,
  output logic      o_fiq_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  // Core samples both request levels once a clock
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq_seen <= 1'b0;
      o_fiq_seen <= 1'b0;
    end else begin
      o_irq_seen <= i_irq;
      o_fiq_seen <= i_fiq;
    end
  end
endmodule // ifmsc_core_model

// >>> dv/ifmsc_top_tb.sv
module ifmsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Bench signals
  logic        i_clk, i_rst, i_wr, i_rd, o_irq, o_fiq, irq_seen, fiq_seen;
  logic [31:0] i_addr, i_wdata, o_rdata, lines;
  int          err_total, n_checks;

  ifmsc_top ifmsc_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_fiq(o_fiq),
    .i_timer0_int(lines[2]), .i_timer1_int(lines[3]), .i_timer2_int(lines[4]),
    .i_timer3_int(lines[5]), .i_flash0_int(lines[6]), .i_flash1_int(lines[7]),
    .i_converter_int(lines[8]), .i_serial0_int(lines[9]), .i_serial1_int(lines[10]),
    .i_pll_lock_int(lines[11]), .i_twi0_master_int(lines[12]), .i_twi0_slave_int(lines[13]),
    .i_twi1_master_int(lines[14]), .i_twi1_slave_int(lines[15]), .i_spi_int(lines[16]),
    .i_external_line_zero(lines[17]), .i_comparator_int(lines[18]),
    .i_supply_monitor_int(lines[19]), .i_external_line_one(lines[20]),
    .i_logic_array_block_a_int(lines[21]), .i_external_line_two(lines[22]),
    .i_external_line_three(lines[23]), .i_logic_array_block_b_int(lines[24]),
    .i_pwm_trip_int(lines[25]));
  ifmsc_core_model ifmsc_core_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_irq(o_irq),
    .i_fiq(o_fiq), .o_irq_seen(irq_seen), .o_fiq_seen(fiq_seen));

  // Clock
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic go(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    go(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    go(1'b0, 1'b1, a, 32'h0);
    i_rd <= 1'b0;
    @(negedge i_clk);
    check(o_rdata, e);
    @(posedge i_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) go(1'b0, 1'b0, 32'h0, 32'h0);
  endtask
  task automatic outs(input logic [3:0] e);
    @(negedge i_clk);
    check({28'h0, o_irq, o_fiq, irq_seen, fiq_seen}, {28'h0, e});
    @(posedge i_clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    complete_run;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata, lines} = {1'b1, 98'h0};
    err_total = 0;
    n_checks = 0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    for (int k = 0; k < 5; k++) begin
      rd(32'hffff_0000 + 32'(4 * k), 32'h0);
      rd(32'hffff_0100 + 32'(4 * k), 32'h0);
    end
    $display("test reset values done");
    lines <= 32'h0221_0000;
    idle(3);
    rd(ifmsc_pkg::ADDR_NORMAL_RAW_SIGNAL, 32'h0221_0000);
    rd(ifmsc_pkg::ADDR_FAST_RAW_SIGNAL, 32'h0221_0000);
    rd(ifmsc_pkg::ADDR_NORMAL_ENABLED_STATUS, 32'h0);
    wr(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK, 32'h0001_0000);
    rd(ifmsc_pkg::ADDR_NORMAL_ENABLED_STATUS, 32'h0001_0000);
    idle(3);
    outs(4'b1010);
    wr(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK, 32'h0);
    rd(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK, 32'h0001_0000);
    wr(ifmsc_pkg::ADDR_NORMAL_ENABLED_STATUS, 32'hffff_ffff);
    rd(ifmsc_pkg::ADDR_NORMAL_ENABLED_STATUS, 32'h0001_0000);
    wr(ifmsc_pkg::ADDR_FAST_ENABLE_MASK, 32'h0201_0000);
    rd(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK, 32'h0);
    rd(ifmsc_pkg::ADDR_FAST_ENABLED_STATUS, 32'h0201_0000);
    rd(ifmsc_pkg::ADDR_NORMAL_RAW_SIGNAL, 32'h0221_0001);
    idle(3);
    outs(4'b0101);
    wr(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK, 32'h1);
    rd(ifmsc_pkg::ADDR_NORMAL_ENABLED_STATUS, 32'h1);
    idle(3);
    outs(4'b1111);
    wr(ifmsc_pkg::ADDR_FAST_MASK_CLEAR, 32'h0001_0000);
    rd(ifmsc_pkg::ADDR_FAST_ENABLE_MASK, 32'h0200_0000);
    wr(ifmsc_pkg::ADDR_NORMAL_MASK_CLEAR, 32'h1);
    rd(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK, 32'h0);
    wr(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK, 32'hffff_ffff);
    rd(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK, 32'h03ff_ffff);
    rd(ifmsc_pkg::ADDR_FAST_ENABLE_MASK, 32'h0);
    lines <= 32'h0;
    wr(ifmsc_pkg::ADDR_NORMAL_MASK_CLEAR, 32'hffff_ffff);
    rd(ifmsc_pkg::ADDR_NORMAL_ENABLE_MASK, 32'h0);
    rd(ifmsc_pkg::ADDR_NORMAL_RAW_SIGNAL, 32'h0);
    $display("test masking done");
    wr(ifmsc_pkg::ADDR_SOFTWARE_INT_CONFIG, 32'h2);
    rd(ifmsc_pkg::ADDR_NORMAL_RAW_SIGNAL, 32'h2);
    rd(ifmsc_pkg::ADDR_NORMAL_ENABLED_STATUS, 32'h2);
    outs(4'b1010);
    wr(ifmsc_pkg::ADDR_SOFTWARE_INT_CONFIG, 32'h4);
    idle(2);
    rd(ifmsc_pkg::ADDR_FAST_RAW_SIGNAL, 32'h3);
    rd(ifmsc_pkg::ADDR_FAST_ENABLED_STATUS, 32'h2);
    rd(ifmsc_pkg::ADDR_NORMAL_RAW_SIGNAL, 32'h1);
    outs(4'b0101);
    wr(ifmsc_pkg::ADDR_SOFTWARE_INT_CONFIG, 32'hffff_ffff);
    rd(ifmsc_pkg::ADDR_SOFTWARE_INT_CONFIG, 32'h6);
    wr(ifmsc_pkg::ADDR_SOFTWARE_INT_CONFIG, 32'h0);
    idle(3);
    outs(4'b0000);
    rd(ifmsc_pkg::ADDR_FAST_MASK_CLEAR, 32'h0);
    $display("test programmed interrupts done");
    complete_run;
  end
endmodule // ifmsc_top_tb
